// [verilog/ttc_timer_pair.sv]
// cascadable pair of eight-bit timer counters with register port
`timescale 1ns/10ps
module ttc_timer_pair
  import ttc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdata,
  input wire logic lowFreqClkPin,
  input wire logic extCountPinA,
  input wire logic extCountPinB,
  input wire logic prescalerTapSelect,
  input wire logic lowSpeedOperation,
  output logic timerAFlipflop,
  output logic timerBFlipflop,
  output logic timerAMatch,
  output logic timerBMatch
);
  localparam int TAP_SHIFT [NUM_TAPS] = '{11, 7, 5, 3, 1};

  logic [7:0] ctlA_q, ctlA_d, ctlB_q, ctlB_d;
  logic [7:0] matchA_q, matchA_d, pwA_q, pwA_d;
  logic [7:0] matchB_q, matchB_d, pwB_q, pwB_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] cntA_q, cntA_d, cntB_q, cntB_d;
  logic ffA_q, ffA_d, ffB_q, ffB_d;
  logic hitA_q, hitA_d, hitB_q, hitB_d;
  logic runAPrev_q, runBPrev_q;
  logic [PRE_BITS-1:0] preCnt_q;
  logic [NUM_TAPS-1:0] fcTap_q;
  logic [FS_DIV_BITS-1:0] fsDiv_q;
  logic fsDiv8Tick_q;
  logic [NUM_PINS-1:0] pinS1_q, pinS2_q, pinS3_q;
  logic [NUM_PINS-1:0] pinEdge;
  logic [2:0] modeA, modeB;
  logic runA, runB, initA, initB, startA, startB;
  logic cascade, bSixteen, warmUp;
  logic tickA, tickB, aOvf;
  logic [15:0] cnt16, match16, pw16, next16;
  logic [9:0] stepA, stepB;

  // =====================================================================
  // decoded control
  assign modeA = ctlA_q[MODE_LSB +: 3];
  assign modeB = ctlB_q[MODE_LSB +: 3];
  assign bSixteen = modeB[2]; // RULE_17
  assign cascade = (modeA == MODE_CASCADE) && bSixteen; // RULE_09
  assign warmUp = cascade && (modeB == MODE_WARM);
  assign runB = ctlB_q[RUN_BIT];
  assign runA = cascade ? runB : ctlA_q[RUN_BIT]; // RULE_11
  assign initB = ctlB_q[FF_BIT];
  assign initA = ctlA_q[FF_BIT];
  assign startA = runA && !runAPrev_q;
  assign startB = runB && !runBPrev_q;
  assign cnt16 = {cntB_q, cntA_q};
  assign match16 = {matchB_q, matchA_q};
  assign pw16 = {pwB_q, pwA_q};

  // =====================================================================
  // pin synchronisers; stage one feeds stage two only
  assign pinEdge = pinS2_q & ~pinS3_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pinS1_q <= '0;
      pinS2_q <= '0;
      pinS3_q <= '0;
    end else begin
      pinS1_q <= {extCountPinB, extCountPinA, lowFreqClkPin};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
    end
  end

  // =====================================================================
  // prescaler: clk stands in for fc; low clock divided by eight
  genvar t;
  generate
    for (t = 0; t < NUM_TAPS; t++) begin : g_tap
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          fcTap_q[t] <= 1'b0;
        end else begin
          fcTap_q[t] <= &preCnt_q[TAP_SHIFT[t]-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      preCnt_q <= '0;
      fsDiv_q <= '0;
      fsDiv8Tick_q <= 1'b0;
    end else begin
      preCnt_q <= preCnt_q + 1'b1;
      fsDiv_q <= fsDiv_q + FS_DIV_BITS'(pinEdge[0]);
      fsDiv8Tick_q <= pinEdge[0] && (&fsDiv_q);
    end
  end

  // =====================================================================
  // source clocks; in cascade both halves run off unit A's selection
  ttc_clock_select u_clk_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .clockSelect(ctlA_q[CK_LSB +: 3]), // RULE_10
    .fcTap(fcTap_q),
    .fsTick(pinEdge[0]),
    .fsDiv8Tick(fsDiv8Tick_q),
    .extTick(pinEdge[1]),
    .prescalerTapSelect(prescalerTapSelect),
    .lowSpeed(lowSpeedOperation),
    .warmUpMode(warmUp),
    .srcTick(tickA)
  );

  ttc_clock_select u_clk_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .clockSelect(ctlB_q[CK_LSB +: 3]),
    .fcTap(fcTap_q),
    .fsTick(pinEdge[0]),
    .fsDiv8Tick(fsDiv8Tick_q),
    .extTick(pinEdge[2]),
    .prescalerTapSelect(prescalerTapSelect),
    .lowSpeed(lowSpeedOperation),
    .warmUpMode(1'b0),
    .srcTick(tickB)
  );

  // =====================================================================
  // one eight-bit step: returns {pulse, flip-flop, count}
  function automatic logic [9:0] step8(input logic [2:0] mode, input logic [7:0] cnt,
    input logic [7:0] match, input logic [7:0] pw, input logic ff, input logic init);
    logic [7:0] c;
    logic f;
    logic p;
    c = cnt;
    f = ff;
    p = 1'b0;
    case (mode)
      MODE_TIMER, MODE_PDO: begin // RULE_06
        if (cnt == match) begin
          c = '0;
          p = 1'b1;
          if (mode == MODE_PDO) begin
            f = ~ff;
          end
        end else begin
          c = cnt + 1'b1;
        end
      end
      MODE_PWM8: begin
        c = cnt + 1'b1;
        if (cnt == CNT_MAX) begin
          f = init;
          p = 1'b1;
        end else if (cnt == pw) begin
          f = ~init;
        end
      end
      default: begin
        // reserved codes hold the count
      end
    endcase
    return {p, f, c};
  endfunction

  // =====================================================================
  // counters and output flip-flops
  always_comb begin
    cntA_d = cntA_q;
    cntB_d = cntB_q;
    ffA_d = ffA_q;
    ffB_d = ffB_q;
    hitA_d = 1'b0;
    hitB_d = 1'b0;
    aOvf = 1'b0;
    next16 = cnt16 + 16'h0001;
    stepA = step8(modeA, cntA_q, matchA_q, pwA_q, ffA_q, initA);
    stepB = step8(bSixteen ? MODE_TIMER : modeB, cntB_q, matchB_q, pwB_q, ffB_q, initB);
    if (cascade) begin
      if (!runB) begin
        cntA_d = '0; // RULE_05
        cntB_d = '0;
      end else if (startB) begin
        ffB_d = initB; // RULE_18
      end else if (tickA) begin
        {cntB_d, cntA_d} = next16;
        aOvf = (cntA_q == CNT_MAX); // RULE_16
        unique case (modeB)
          MODE_T16: if (cnt16 == match16) begin
            {cntB_d, cntA_d} = '0;
            hitB_d = 1'b1;
          end
          MODE_WARM: if (cntB_q == matchB_q) begin
            {cntB_d, cntA_d} = '0; // lower byte ignored for warm-up
            hitB_d = 1'b1;
          end
          MODE_PWM16: begin
            if (cnt16 == CNT16_MAX) begin
              ffB_d = initB;
              hitB_d = 1'b1;
            end else if (cnt16 == pw16) begin
              ffB_d = ~initB;
            end
          end
          MODE_PPG16: begin
            if (cnt16 == match16) begin
              {cntB_d, cntA_d} = '0;
              ffB_d = initB;
              hitB_d = 1'b1;
            end else if (cnt16 == pw16) begin
              ffB_d = ~initB;
            end
          end
          default: begin
          end
        endcase
      end
    end else begin
      if (!runA) begin
        cntA_d = '0; // RULE_05
      end else if (startA) begin
        ffA_d = initA; // RULE_18
      end else if (tickA) begin
        if (modeA == MODE_CASCADE) begin
          // half of a pair whose upper unit is not yet 16-bit: free-run
          cntA_d = cntA_q + 1'b1;
          aOvf = (cntA_q == CNT_MAX);
        end else begin
          {hitA_d, ffA_d, cntA_d} = stepA;
          aOvf = stepA[9];
        end
      end
      if (!runB) begin
        cntB_d = '0; // RULE_05
      end else if (startB) begin
        ffB_d = initB; // RULE_18
      end else if (bSixteen ? aOvf : tickB) begin // RULE_16
        {hitB_d, ffB_d, cntB_d} = stepB;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cntA_q <= '0;
      cntB_q <= '0;
      ffA_q <= 1'b0;
      ffB_q <= 1'b0;
      hitA_q <= 1'b0;
      hitB_q <= 1'b0;
      runAPrev_q <= 1'b0;
      runBPrev_q <= 1'b0;
    end else begin
      cntA_q <= cntA_d;
      cntB_q <= cntB_d;
      ffA_q <= ffA_d;
      ffB_q <= ffB_d;
      hitA_q <= hitA_d;
      hitB_q <= hitB_d;
      runAPrev_q <= runA;
      runBPrev_q <= runB;
    end
  end

  // =====================================================================
  // register port; fields are frozen while a unit's own run bit is set so a stray
  // write cannot disturb a live count, only the run bit gets through
  always_comb begin
    ctlA_d = ctlA_q;
    ctlB_d = ctlB_q;
    matchA_d = matchA_q;
    pwA_d = pwA_q;
    matchB_d = matchB_q;
    pwB_d = pwB_q;
    rdata_d = '0;
    if (regWrite) begin
      unique case (regAddr)
        OFS_CTL_A: begin
          if (ctlA_q[RUN_BIT]) begin
            ctlA_d[RUN_BIT] = regWdata[RUN_BIT];
          end else begin
            ctlA_d = regWdata; // RULE_08
          end
        end
        OFS_CTL_B: begin
          if (ctlB_q[RUN_BIT]) begin
            ctlB_d[RUN_BIT] = regWdata[RUN_BIT];
          end else begin
            ctlB_d = regWdata; // RULE_08
          end
        end
        OFS_MATCH_A: matchA_d = regWdata; // RULE_01
        OFS_PW_A: pwA_d = regWdata;
        OFS_MATCH_B: matchB_d = regWdata; // RULE_13
        OFS_PW_B: pwB_d = regWdata;
        default: begin
        end
      endcase
    end
    if (regRead) begin
      unique case (regAddr)
        OFS_CTL_A: rdata_d = ctlA_q;
        OFS_CTL_B: rdata_d = ctlB_q;
        OFS_MATCH_A: rdata_d = matchA_q;
        OFS_PW_A: rdata_d = pwA_q;
        OFS_MATCH_B: rdata_d = matchB_q;
        OFS_PW_B: rdata_d = pwB_q;
        OFS_COUNT_A: rdata_d = cntA_q;
        OFS_COUNT_B: rdata_d = cntB_q;
        OFS_STATUS: begin
          rdata_d[STAT_FF_A] = ffA_q;
          rdata_d[STAT_FF_B] = ffB_q;
          rdata_d[STAT_RUN_A] = runA;
          rdata_d[STAT_RUN_B] = runB;
          rdata_d[STAT_CASC] = cascade;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctlA_q <= CTL_RESET;
      ctlB_q <= CTL_RESET;
      matchA_q <= MATCH_RESET;
      pwA_q <= PW_RESET;
      matchB_q <= MATCH_RESET;
      pwB_q <= PW_RESET;
      rdata_q <= '0;
    end else begin
      ctlA_q <= ctlA_d;
      ctlB_q <= ctlB_d;
      matchA_q <= matchA_d;
      pwA_q <= pwA_d;
      matchB_q <= matchB_d;
      pwB_q <= pwB_d;
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;
  assign timerAFlipflop = ffA_q;
  assign timerBFlipflop = ffB_q;
  assign timerAMatch = hitA_q;
  assign timerBMatch = hitB_q;

  // =====================================================================
  // checks
  sequence s_startB;
    !runB ##1 runB;
  endsequence

  a_stop_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
    !runA |=> cntA_q == 8'h00) // RULE_05
    else $error("unit A count not cleared while stopped");

  a_stop_clears_b: assert property (@(posedge clk) disable iff (sys_rst)
    !runB ##1 !runB |-> cntB_q == 8'h00) // RULE_05
    else $error("unit B count not cleared while stopped");

  a_start_ff_init: assert property (@(posedge clk) disable iff (sys_rst)
    s_startB |=> ffB_q == $past(initB)) // RULE_18
    else $error("unit B flip-flop not loaded at start");

  a_fields_take: assert property (@(posedge clk) disable iff (sys_rst)
    (regWrite && regAddr == OFS_CTL_A && !ctlA_q[RUN_BIT]) |=> ctlA_q == $past(regWdata)) // RULE_08
    else $error("control write while stopped not taken");

  a_fields_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (regWrite && regAddr == OFS_CTL_B && ctlB_q[RUN_BIT]) |=>
      ctlB_q[FF_BIT:CK_LSB] == $past(ctlB_q[FF_BIT:CK_LSB]) && ctlB_q[2:0] == $past(ctlB_q[2:0])) // RULE_08
    else $error("control fields changed while running");

  a_read_match: assert property (@(posedge clk) disable iff (sys_rst)
    (regRead && regAddr == OFS_MATCH_A) |=> regRdata == $past(matchA_q)) // RULE_01
    else $error("match value read back wrong");

  a_cascade_run: assert property (@(posedge clk) disable iff (sys_rst)
    (cascade && !ctlB_q[RUN_BIT] && ctlA_q[RUN_BIT]) |=> cntA_q == 8'h00) // RULE_11
    else $error("cascade lower half ran without unit B start");

  a_b_counts_ovf: assert property (@(posedge clk) disable iff (sys_rst)
    (bSixteen && runB && !startB && !tickA) |=> $stable(cntB_q)) // RULE_16
    else $error("unit B counted without an overflow from unit A");
endmodule // ttc_timer_pair

// [verilog/ttc_pkg.sv]
// constants shared by the eight-bit timer pair control block
// =====================================================================
// How it works
// RULE_01 - unit A has control, match, pulse-width registers
// RULE_02 - software leaves A match alone while running
// RULE_03 - A pulse width fixed while running, except PWM
// RULE_04 - three-bit field picks the source clock
// RULE_05 - run bit zero stops and clears; one starts
// RULE_06 - A mode codes: timer, divider, PWM, cascade
// RULE_07 - software keeps fields while running or stopping
// RULE_08 - fields load in the write that starts
// RULE_09 - cascade needs A mode 011, B picks mode
// RULE_10 - cascade source clock comes from unit A
// RULE_11 - cascade run and flip-flop come from B
// RULE_12 - full-rate clock in slow only for warm-up
// RULE_13 - unit B has its own three registers
// RULE_14 - software leaves B match alone while running
// RULE_15 - B pulse width fixed while running, except PWM
// RULE_16 - B in 16-bit modes counts A overflow
// RULE_17 - B mode codes: 16-bit timer, warm-up, PWM, pulse
// RULE_18 - flip-flop bit gives output level at start
package ttc_pkg;
  // =====================================================================
  // widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int PRE_BITS = 11;
  localparam int FS_DIV_BITS = 3;
  localparam int NUM_TAPS = 5;
  localparam int NUM_PINS = 3;

  // =====================================================================
  // register offsets
  localparam logic [7:0] OFS_CTL_A = 8'h29;
  localparam logic [7:0] OFS_CTL_B = 8'h2a;
  localparam logic [7:0] OFS_MATCH_A = 8'h2b;
  localparam logic [7:0] OFS_PW_A = 8'h2c;
  localparam logic [7:0] OFS_MATCH_B = 8'h2d;
  localparam logic [7:0] OFS_PW_B = 8'h2e;
  localparam logic [7:0] OFS_COUNT_A = 8'h2f;
  localparam logic [7:0] OFS_COUNT_B = 8'h30;
  localparam logic [7:0] OFS_STATUS = 8'h31;

  // =====================================================================
  // reset values and field layout
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] MATCH_RESET = 8'hff;
  localparam logic [7:0] PW_RESET = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [15:0] CNT16_MAX = 16'hffff;
  localparam int FF_BIT = 7;
  localparam int CK_LSB = 4;
  localparam int RUN_BIT = 3;
  localparam int MODE_LSB = 0;
  localparam int STAT_FF_A = 0;
  localparam int STAT_FF_B = 1;
  localparam int STAT_RUN_A = 2;
  localparam int STAT_RUN_B = 3;
  localparam int STAT_CASC = 4;

  // =====================================================================
  // source clock codes
  localparam logic [2:0] CK_DIV2048 = 3'h0;
  localparam logic [2:0] CK_DIV128 = 3'h1;
  localparam logic [2:0] CK_DIV32 = 3'h2;
  localparam logic [2:0] CK_DIV8 = 3'h3;
  localparam logic [2:0] CK_LOW = 3'h4;
  localparam logic [2:0] CK_DIV2 = 3'h5;
  localparam logic [2:0] CK_FULL = 3'h6;
  localparam logic [2:0] CK_PIN = 3'h7;

  // =====================================================================
  // operating modes
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_PDO = 3'h1;
  localparam logic [2:0] MODE_PWM8 = 3'h2;
  localparam logic [2:0] MODE_CASCADE = 3'h3;
  localparam logic [2:0] MODE_T16 = 3'h4;
  localparam logic [2:0] MODE_WARM = 3'h5;
  localparam logic [2:0] MODE_PWM16 = 3'h6;
  localparam logic [2:0] MODE_PPG16 = 3'h7;
endpackage

// [verilog/ttc_clock_select.sv]
// source clock selection for one timer unit
`timescale 1ns/10ps
module ttc_clock_select
  import ttc_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] clockSelect,
  input wire logic [NUM_TAPS-1:0] fcTap,
  input wire logic fsTick,
  input wire logic fsDiv8Tick,
  input wire logic extTick,
  input wire logic prescalerTapSelect,
  input wire logic lowSpeed,
  input wire logic warmUpMode,
  output logic srcTick
);
  logic tick_d;
  logic tick_q;

  // =====================================================================
  // tap mux; fc-derived taps are dead in low-speed operation
  always_comb begin
    tick_d = 1'b0;
    unique case (clockSelect)
      CK_DIV2048: tick_d = (prescalerTapSelect || lowSpeed) ? fsDiv8Tick : fcTap[0]; // RULE_04
      CK_DIV128: tick_d = !lowSpeed && fcTap[1];
      CK_DIV32: tick_d = !lowSpeed && fcTap[2];
      CK_DIV8: tick_d = !lowSpeed && fcTap[3];
      CK_LOW: tick_d = fsTick;
      CK_DIV2: tick_d = !lowSpeed && fcTap[4];
      CK_FULL: tick_d = !lowSpeed || warmUpMode; // RULE_12
      CK_PIN: tick_d = extTick;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

  assign srcTick = tick_q;

  a_slow_full_gate: assert property (@(posedge clk) disable iff (sys_rst)
    (lowSpeed && !warmUpMode && clockSelect == CK_FULL) |=> !srcTick) // RULE_12
    else $error("full-rate tick in low-speed operation outside warm-up");
endmodule // ttc_clock_select

// [testbench/ttc_timer_pair_tb_top.sv]
// self-checking testbench for the eight-bit timer pair control block
`timescale 1ns/10ps
module ttc_timer_pair_tb_top;
  import ttc_pkg::*;
  // =====================================================================
  // clock, reset, stimulus
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic lowFreqClkPin = 1'b0;
  logic extCountPinA = 1'b0;
  logic extCountPinB = 1'b0;
  logic prescalerTapSelect = 1'b0;
  logic lowSpeedOperation = 1'b0;
  logic timerAFlipflop;
  logic timerBFlipflop;
  logic timerAMatch;
  logic timerBMatch;
  int n_mismatch = 0;
  int checked = 0;
  int fsCnt = 0;
  initial begin
    forever #4 clk = ~clk;
  end
  // slow clock: one rising edge every ten system cycles
  always @(posedge clk) begin
    fsCnt <= (fsCnt == 9) ? 0 : fsCnt + 1;
    lowFreqClkPin <= (fsCnt >= 5);
  end
  ttc_timer_pair i_ttc_timer_pair (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .lowFreqClkPin(lowFreqClkPin),
    .extCountPinA(extCountPinA), .extCountPinB(extCountPinB), .prescalerTapSelect(prescalerTapSelect),
    .lowSpeedOperation(lowSpeedOperation), .timerAFlipflop(timerAFlipflop), .timerBFlipflop(timerBFlipflop),
    .timerAMatch(timerAMatch), .timerBMatch(timerBMatch));
  // =====================================================================
  // bus and compare tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(what, {24'h0, exp}, {24'h0, d});
  endtask
  // cycles between two match pulses; -1 when no pulse arrives in time
  task automatic period(input bit unitB, input int bound, output int n);
    int i;
    n = -1;
    for (i = 0; i < bound; i++) begin
      @(negedge clk);
      if ((unitB ? timerBMatch : timerAMatch) === 1'b1) break;
    end
    if (i < bound) begin
      for (n = 1; n <= bound; n++) begin
        @(negedge clk);
        if ((unitB ? timerBMatch : timerAMatch) === 1'b1) break;
      end
    end
  endtask
  // pulses only the selected unit's pin so a swapped pin wiring shows up
  task automatic ext_edges(input bit unitB, input int k);
    repeat (k) begin
      @(posedge clk);
      {extCountPinB, extCountPinA} <= unitB ? 2'b10 : 2'b01;
      repeat (3) @(posedge clk);
      {extCountPinB, extCountPinA} <= 2'b00;
      repeat (3) @(posedge clk);
    end
  endtask
  // =====================================================================
  // scenarios
  task automatic t_reset_and_map;
    chk_rd("ctl A", OFS_CTL_A, 8'h00);
    chk_rd("match A", OFS_MATCH_A, 8'hff);
    chk_rd("pw A", OFS_PW_A, 8'h00);
    chk_rd("ctl B", OFS_CTL_B, 8'h00);
    chk_rd("match B", OFS_MATCH_B, 8'hff);
    chk_rd("pw B", OFS_PW_B, 8'h00);
    wr(8'h00, 8'h5a);
    chk_rd("unmapped", 8'h00, 8'h00);
    wr(OFS_MATCH_A, 8'h02);
    wr(OFS_PW_B, 8'h3c);
    chk_rd("match A rw", OFS_MATCH_A, 8'h02);
    chk_rd("pw B rw", OFS_PW_B, 8'h3c);
    $display("test reset_and_map done");
  endtask
  task automatic t_source_clocks;
    logic [2:0] codes [8] = '{CK_DIV2048, CK_DIV128, CK_DIV32, CK_DIV8, CK_DIV2, CK_FULL, CK_LOW, CK_DIV2048};
    int divs [8] = '{2048, 128, 32, 8, 2, 1, 10, 80};
    int n;
    for (int k = 0; k < 8; k++) begin
      prescalerTapSelect <= (k == 7);
      wr(OFS_CTL_A, {1'b0, codes[k], 1'b1, MODE_TIMER});
      period(1'b0, 3 * divs[k] + 40, n);
      chk("match period A", 3 * divs[k], n);
      wr(OFS_CTL_A, {1'b0, codes[k], 1'b0, MODE_TIMER});
    end
    prescalerTapSelect <= 1'b0;
    $display("test source_clocks done");
  endtask
  task automatic t_run_stop_fields;
    wr(OFS_CTL_A, 8'h78);
    ext_edges(1'b0, 2);
    chk_rd("count A ext", OFS_COUNT_A, 8'h02);
    wr(OFS_CTL_A, 8'h99);
    chk_rd("ctl A frozen", OFS_CTL_A, 8'h78);
    wr(OFS_CTL_A, 8'h70);
    chk_rd("count A clear", OFS_COUNT_A, 8'h00);
    chk_rd("status stop", OFS_STATUS, 8'h00);
    wr(OFS_CTL_A, 8'he9);
    @(posedge clk);
    #1 chk("ff A init one", 1'b1, timerAFlipflop);
    chk_rd("ctl A start load", OFS_CTL_A, 8'he9);
    wr(OFS_CTL_A, 8'he1);
    wr(OFS_CTL_A, 8'h68);
    @(posedge clk);
    #1 chk("ff A init zero", 1'b0, timerAFlipflop);
    wr(OFS_CTL_A, 8'h60);
    $display("test run_stop_fields done");
  endtask
  task automatic t_modes_a;
    int n;
    wr(OFS_PW_A, 8'h80);
    wr(OFS_CTL_A, 8'h6a);
    period(1'b0, 600, n);
    chk("pwm8 period", 256, n);
    wr(OFS_CTL_A, 8'h62);
    wr(OFS_CTL_A, 8'h6c);
    repeat (20) @(posedge clk);
    chk_rd("reserved mode count", OFS_COUNT_A, 8'h00);
    wr(OFS_CTL_A, 8'h64);
    $display("test modes_a done");
  endtask
  task automatic t_cascade;
    int n;
    wr(OFS_MATCH_A, 8'h02);
    wr(OFS_MATCH_B, 8'h01);
    wr(OFS_CTL_B, 8'hf4);
    // unit A's own run bit set, but in cascade only unit B may start the pair
    wr(OFS_CTL_A, 8'h6b);
    chk_rd("cascade A held", OFS_COUNT_A, 8'h00);
    wr(OFS_CTL_B, 8'hfc);
    @(posedge clk);
    #1 chk("ff B cascade", 1'b1, timerBFlipflop);
    chk_rd("status cascade", OFS_STATUS, 8'h1e);
    period(1'b1, 700, n);
    chk("cascade period", 259, n);
    wr(OFS_CTL_B, 8'hf4);
    lowSpeedOperation <= 1'b1;
    wr(OFS_CTL_B, 8'h0d);
    period(1'b1, 700, n);
    chk("warm-up period", 257, n);
    wr(OFS_CTL_B, 8'h05);
    wr(OFS_CTL_B, 8'h0c);
    period(1'b1, 700, n);
    chk("full rate dead", -1, n);
    wr(OFS_CTL_B, 8'h04);
    lowSpeedOperation <= 1'b0;
    $display("test cascade done");
  endtask
  task automatic t_unit_b;
    int n;
    wr(OFS_CTL_A, 8'h63);
    wr(OFS_CTL_A, 8'h68);
    // B in a 16-bit code without cascade: its own slow source must be ignored
    wr(OFS_CTL_B, 8'h0c);
    period(1'b1, 40, n);
    chk("B on A pulses", 6, n);
    wr(OFS_CTL_B, 8'h04);
    wr(OFS_CTL_A, 8'h60);
    wr(OFS_MATCH_B, 8'h05);
    wr(OFS_CTL_B, 8'h78);
    ext_edges(1'b1, 2);
    chk_rd("count B ext", OFS_COUNT_B, 8'h02);
    chk_rd("count A idle", OFS_COUNT_A, 8'h00);
    wr(OFS_CTL_B, 8'h70);
    $display("test unit_b done");
  endtask
  // =====================================================================
  // sequence and verdict
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_and_map();
    t_source_clocks();
    t_run_stop_fields();
    t_modes_a();
    t_cascade();
    t_unit_b();
    test_done();
  end
  // the whole run needs roughly 15000 cycles
  initial begin
    repeat (50000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule // ttc_timer_pair_tb_top
